// file: hdl/lsm_mode_ctrl.sv
// Operating-mode controller of the LIN system basis chip
//
// What this block does
// - Normal: paths, regulator, undervoltage, watchdog active.
// - Reset pin low forces fail-safe from any mode but unpowered and sleep.
// - Enable falls, transmit high: enter silent.
// - Silent: no transmit, termination only on low bus, receive high.
// - Silent request accepted whatever other input levels, undervoltage and reset pin low aside.
// - Undervoltage in silent: reset low, fail-safe.
// - Low bus in silent/sleep enables receiver, termination.
// - Filtered bus pulse wakes to fail-safe, receive low.
// - Enable high after remote wake goes to normal.
// - Enable falls, transmit low: enter sleep.
// - Sleep: regulator off, reset and receive low.
// - Sleep request accepted whatever other input levels, undervoltage and reset pin low aside.
// - Enable rise in sleep/silent: fail-safe, then normal.
// - Power-up: fail-safe, regulator on, reset pulse.
// - Fail-safe holds until enable high, then normal.
// - Battery low in silent/sleep forces fail-safe.
// - Fail-safe transmit pin reports last wake source.
// - Mode requests ignored while reset pulse runs.
// - Bus low in normal pre-arms the wake filter.
// - Filtered local switch low wakes, both pins low.
// - Local switch needs long release before re-arming.
// - Normal clears indications, keeps last wake source.
`timescale 1ns/1ps
module lsm_mode_ctrl #(
  parameter logic [lsm_pkg::CNT_W-1:0] RESET_CYC      = lsm_pkg::RESET_CYC,
  parameter logic [lsm_pkg::CNT_W-1:0] RAMP_CYC       = lsm_pkg::RAMP_CYC,
  parameter logic [lsm_pkg::CNT_W-1:0] WDOG_CYC       = lsm_pkg::WDOG_CYC,
  parameter logic [lsm_pkg::CNT_W-1:0] BUS_WAKE_CYC   = lsm_pkg::BUS_WAKE_CYC,
  parameter logic [lsm_pkg::CNT_W-1:0] LOCAL_WAKE_CYC = lsm_pkg::LOCAL_WAKE_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        EN,
  input  wire logic        TX_DATA_PIN_I,
  output      logic        TX_DATA_PIN_O,
  output      logic        TX_DATA_PIN_OE,
  output      logic        RX_DATA_PIN,
  input  wire logic        BUS_RX,
  input  wire logic        BUS_BELOW_PREWAKE,
  input  wire logic        LOCAL_SWITCH_INPUT,
  input  wire logic        BATTERY_SUPPLY_LOW,
  input  wire logic        VCC_UNDERVOLTAGE,
  input  wire logic        WATCHDOG_TRIGGER_N,
  input  wire logic        RESET_OUT_N_I,
  output      logic        RESET_OUT_N_O,
  output      logic        RESET_OUT_N_OE,
  output      logic        TX_PATH_EN,
  output      logic        RX_PATH_EN,
  output      logic        REGULATOR_EN,
  output      logic        UV_DETECT_EN,
  output      logic        WATCHDOG_EN,
  output      logic        EXT_REGULATOR_SWITCH,
  output      logic        TERMINATION_EN,
  output      logic        BUS_RECEIVER_EN,
  output      lsm_pkg::lsm_mode_e MODE
);
  import lsm_pkg::*;

  // State
  lsm_mode_e        mode;
  logic             en_q;
  logic             trig_q;
  logic             sel_busy;
  logic [CNT_W-1:0] sel_cnt;
  logic [CNT_W-1:0] ramp_cnt;
  logic [CNT_W-1:0] rst_cnt;
  logic [CNT_W-1:0] wd_cnt;
  logic             wk_req;
  logic             last_local;
  logic             prewake;
  logic             rst_oe;

  // Next values
  lsm_mode_e        next_mode;
  logic             next_sel_busy;
  logic [CNT_W-1:0] next_sel_cnt;
  logic [CNT_W-1:0] next_ramp_cnt;
  logic [CNT_W-1:0] next_rst_cnt;
  logic [CNT_W-1:0] next_wd_cnt;
  logic             next_wk_req;
  logic             next_last_local;
  logic             next_prewake;
  logic             next_tx_path;
  logic             next_rx_path;
  logic             next_reg;
  logic             next_uv;
  logic             next_wdog;
  logic             next_ext;
  logic             next_term;
  logic             next_rcv;
  logic             next_rxd;
  logic             next_txd_o;
  logic             next_txd_oe;

  // Decodes
  logic en_rise;
  logic en_fall;
  logic trig_fall;
  logic is_normal;
  logic is_fs;
  logic low_pwr;
  logic rst_busy;
  logic pin_low;
  logic wake_bus;
  logic wake_loc;
  logic any_wake;
  logic uv_hit;
  logic wd_run;
  logic wd_exp;
  logic sel_done;
  logic start_ramp;
  logic start_rst;

  lsm_wake_if wk [NWAKE] ();

  assign en_rise   = EN && !en_q;
  assign en_fall   = !EN && en_q;
  assign trig_fall = !WATCHDOG_TRIGGER_N && trig_q;
  assign is_normal = mode == LSM_NORMAL;
  assign is_fs     = mode == LSM_FAILSAFE;
  assign low_pwr   = (mode == LSM_SILENT) || (mode == LSM_SLEEP);
  assign rst_busy  = (ramp_cnt != CNT_ZERO) || (rst_cnt != CNT_ZERO);
  // Pin is read back so another party's reset counts; sleep pulls it itself
  assign pin_low   = !RESET_OUT_N_I && (mode != LSM_UNPOWERED) && (mode != LSM_SLEEP);
  assign wake_bus  = wk[WK_BUS].wake && low_pwr;
  assign wake_loc  = wk[WK_LOCAL].wake && low_pwr;
  assign any_wake  = wake_bus || wake_loc;
  // Sleep has the regulator off, so its undervoltage is expected and ignored
  assign uv_hit    = VCC_UNDERVOLTAGE && (is_normal || is_fs || mode == LSM_SILENT)
                     && !rst_busy;
  assign wd_run    = (is_normal || is_fs) && !rst_busy;
  assign wd_exp    = wd_run && (wd_cnt == WDOG_CYC);
  // Transmit is sampled after the lead that the host may give enable
  assign sel_done  = sel_busy && (sel_cnt == MODESEL_CYC);

  // Bus filter: dominant counts in normal too, so a low level seen
  // before the mode change still yields a wake at the next release
  assign wk[WK_BUS].act = !BUS_RX && (is_normal || prewake || BUS_BELOW_PREWAKE);
  assign wk[WK_BUS].run = is_normal || low_pwr;
  assign wk[WK_LOCAL].act = !LOCAL_SWITCH_INPUT;
  assign wk[WK_LOCAL].run = low_pwr;

  generate
    for (genvar g = 0; g < NWAKE; g++) begin : g_wake
      lsm_wake_filter #(
        .FILT_CYC   ((g == WK_BUS) ? BUS_WAKE_CYC : LOCAL_WAKE_CYC),
        .REARM_CYC  ((g == WK_BUS) ? BUS_REARM_CYC : REARM_CYC),
        .ON_RELEASE ((g == WK_BUS) ? 1'b1 : 1'b0)
      ) u_filt (
        .clk    (CLK),
        .resetn (RESETN),
        .w      (wk[g])
      );
    end
  endgenerate

  // Mode transitions
  always_comb begin
    next_mode = mode;
    if (pin_low) begin
      next_mode = LSM_FAILSAFE;
    end else begin
      case (mode)
        LSM_UNPOWERED: begin
          if (!BATTERY_SUPPLY_LOW) begin
            next_mode = LSM_FAILSAFE;
          end
        end
        LSM_FAILSAFE: begin
          if (EN && !rst_busy && !start_rst) begin
            next_mode = LSM_NORMAL;
          end
        end
        LSM_NORMAL: begin
          if (uv_hit || wd_exp) begin
            next_mode = LSM_FAILSAFE;
          end else if (sel_done) begin
            // Bus, local switch and battery levels play no part
            next_mode = TX_DATA_PIN_I ? LSM_SILENT : LSM_SLEEP;
          end
        end
        LSM_SILENT: begin
          if (uv_hit || BATTERY_SUPPLY_LOW || any_wake || en_rise) begin
            next_mode = LSM_FAILSAFE;
          end
        end
        LSM_SLEEP: begin
          if (BATTERY_SUPPLY_LOW || any_wake || en_rise) begin
            next_mode = LSM_FAILSAFE;
          end
        end
        default: next_mode = LSM_FAILSAFE;
      endcase
    end
  end

  // Reset pulse and regulator ramp
  assign start_ramp = ((mode == LSM_UNPOWERED) && (next_mode == LSM_FAILSAFE))
                      || ((mode == LSM_SLEEP) && (next_mode == LSM_FAILSAFE))
                      || ((mode == LSM_SILENT) && en_rise);
  assign start_rst  = uv_hit || wd_exp;

  always_comb begin
    next_ramp_cnt = ramp_cnt;
    next_rst_cnt  = rst_cnt;
    if (start_ramp) begin
      next_ramp_cnt = RAMP_CYC;
    end else if (ramp_cnt != CNT_ZERO) begin
      next_ramp_cnt = ramp_cnt - CNT_ONE;
    end
    // The reset time starts once the regulator has had its ramp time
    if (start_rst || (ramp_cnt == CNT_ONE)) begin
      next_rst_cnt = RESET_CYC;
    end else if (rst_cnt != CNT_ZERO) begin
      next_rst_cnt = rst_cnt - CNT_ONE;
    end
  end

  // Mode-select window and watchdog
  always_comb begin
    next_sel_busy = sel_busy;
    next_sel_cnt  = sel_cnt;
    if (next_mode != LSM_NORMAL || mode != LSM_NORMAL) begin
      next_sel_busy = 1'b0;
      next_sel_cnt  = CNT_ZERO;
    end else if (en_fall && !rst_busy && !sel_busy) begin
      next_sel_busy = 1'b1;
      next_sel_cnt  = CNT_ZERO;
    end else if (sel_busy) begin
      next_sel_cnt  = sel_cnt + CNT_ONE;
    end
    if (!wd_run || trig_fall) begin
      next_wd_cnt = CNT_ZERO;
    end else if (wd_cnt != WDOG_CYC) begin
      next_wd_cnt = wd_cnt + CNT_ONE;
    end else begin
      next_wd_cnt = wd_cnt;
    end
  end

  // Wake flags; set only in low power, cleared only on reaching normal
  always_comb begin
    next_wk_req     = wk_req;
    next_last_local = last_local;
    if (any_wake) begin
      next_wk_req     = 1'b1;
      next_last_local = wake_loc;
    end else if (next_mode == LSM_NORMAL) begin
      next_wk_req     = 1'b0;
    end
    next_prewake = (next_mode == LSM_SILENT || next_mode == LSM_SLEEP)
                   && (prewake || BUS_BELOW_PREWAKE);
  end

  // Per-mode outputs, registered from the next mode
  always_comb begin
    next_tx_path = 1'b0;
    next_rx_path = 1'b0;
    next_reg     = 1'b0;
    next_uv      = 1'b0;
    next_wdog    = 1'b0;
    next_ext     = 1'b0;
    next_term    = 1'b0;
    next_rcv     = 1'b0;
    next_rxd     = 1'b0;
    next_txd_o   = 1'b1;
    next_txd_oe  = 1'b0;
    case (next_mode)
      LSM_NORMAL: begin
        next_tx_path = 1'b1;
        next_rx_path = 1'b1;
        next_reg     = 1'b1;
        next_uv      = 1'b1;
        next_wdog    = 1'b1;
        next_ext     = 1'b1;
        next_term    = 1'b1;
        next_rcv     = 1'b1;
        next_rxd     = BUS_RX;
      end
      LSM_FAILSAFE: begin
        next_reg     = 1'b1;
        next_uv      = 1'b1;
        next_wdog    = 1'b1;
        next_ext     = 1'b1;
        next_term    = 1'b1;
        next_rxd     = !next_wk_req;
        next_txd_oe  = 1'b1;
        next_txd_o   = !next_last_local;
      end
      LSM_SILENT: begin
        next_reg     = 1'b1;
        next_uv      = 1'b1;
        next_term    = next_prewake;
        next_rcv     = next_prewake;
        next_rxd     = 1'b1;
      end
      LSM_SLEEP: begin
        next_term    = next_prewake;
        next_rcv     = next_prewake;
      end
      default: begin
        next_rxd     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      mode       <= MODE_RST;
      en_q       <= 1'b0;
      trig_q     <= 1'b1;
      sel_busy   <= 1'b0;
      sel_cnt    <= CNT_ZERO;
      ramp_cnt   <= CNT_ZERO;
      rst_cnt    <= CNT_ZERO;
      wd_cnt     <= CNT_ZERO;
      wk_req     <= 1'b0;
      last_local <= 1'b0;
      prewake    <= 1'b0;
    end else begin
      mode       <= next_mode;
      en_q       <= EN;
      trig_q     <= WATCHDOG_TRIGGER_N;
      sel_busy   <= next_sel_busy;
      sel_cnt    <= next_sel_cnt;
      ramp_cnt   <= next_ramp_cnt;
      rst_cnt    <= next_rst_cnt;
      wd_cnt     <= next_wd_cnt;
      wk_req     <= next_wk_req;
      last_local <= next_last_local;
      prewake    <= next_prewake;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      TX_PATH_EN           <= 1'b0;
      RX_PATH_EN           <= 1'b0;
      REGULATOR_EN         <= 1'b0;
      UV_DETECT_EN         <= 1'b0;
      WATCHDOG_EN          <= 1'b0;
      EXT_REGULATOR_SWITCH <= 1'b0;
      TERMINATION_EN       <= 1'b0;
      BUS_RECEIVER_EN      <= 1'b0;
      RX_DATA_PIN          <= 1'b0;
      TX_DATA_PIN_O        <= 1'b1;
      TX_DATA_PIN_OE       <= 1'b0;
      rst_oe               <= 1'b1;
    end else begin
      TX_PATH_EN           <= next_tx_path;
      RX_PATH_EN           <= next_rx_path;
      REGULATOR_EN         <= next_reg;
      UV_DETECT_EN         <= next_uv;
      WATCHDOG_EN          <= next_wdog;
      EXT_REGULATOR_SWITCH <= next_ext;
      TERMINATION_EN       <= next_term;
      BUS_RECEIVER_EN      <= next_rcv;
      RX_DATA_PIN          <= next_rxd;
      TX_DATA_PIN_O        <= next_txd_o;
      TX_DATA_PIN_OE       <= next_txd_oe;
      // Reset is held through ramp, pulse, sleep and no supply
      rst_oe <= (next_ramp_cnt != CNT_ZERO) || (next_rst_cnt != CNT_ZERO)
                || (next_mode == LSM_SLEEP)
                || (next_mode == LSM_UNPOWERED);
    end
  end

  // Open drain: only ever pulls low
  assign RESET_OUT_N_O  = 1'b0;
  assign RESET_OUT_N_OE = rst_oe;
  assign MODE           = mode;

endmodule

// file: hdl/lsm_wake_filter.sv
// Edge, hold-time and re-arm filter for one wake source
`timescale 1ns/1ps
module lsm_wake_filter #(
  parameter logic [lsm_pkg::CNT_W-1:0] FILT_CYC   = lsm_pkg::BUS_WAKE_CYC,
  parameter logic [lsm_pkg::CNT_W-1:0] REARM_CYC  = lsm_pkg::BUS_REARM_CYC,
  parameter bit                        ON_RELEASE = 1'b1
) (
  input wire logic       clk,
  input wire logic       resetn,
  lsm_wake_if.filt       w
);
  import lsm_pkg::*;

  logic [CNT_W-1:0] rel_cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic             armed;
  logic             qual;
  logic             wake;
  logic             rel_done;
  logic             hold_done;
  logic             fire;
  logic             next_armed;

  assign rel_done  = rel_cnt == REARM_CYC;
  assign hold_done = hold_cnt == FILT_CYC;
  // Release variant waits for the level to end; hold variant fires at the hold time
  assign fire = ON_RELEASE ? (qual && !w.act && w.run)
                           : (hold_done && w.act && armed && w.run);
  // A level already active while not running is consumed, so it must
  // go inactive for the re-arm time before a new edge counts
  assign next_armed = (!w.act && rel_done) ? 1'b1 :
                      (w.act && (!w.run || fire)) ? 1'b0 : armed;
  assign w.wake = wake;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rel_cnt  <= CNT_ZERO;
      hold_cnt <= CNT_ZERO;
      armed    <= 1'b0;
      qual     <= 1'b0;
      wake     <= 1'b0;
    end else begin
      rel_cnt  <= w.act ? CNT_ZERO : (rel_done ? rel_cnt : rel_cnt + CNT_ONE);
      hold_cnt <= (w.act && w.run && armed && !hold_done) ? hold_cnt + CNT_ONE :
                  (w.act && w.run && armed) ? hold_cnt : CNT_ZERO;
      armed    <= next_armed;
      qual     <= (!w.run || fire) ? 1'b0 : (qual || (hold_done && w.act && armed));
      wake     <= fire;
    end
  end
endmodule

// file: inc/lsm_pkg.sv
// Constants, timing counts and mode encoding for the LIN mode controller
package lsm_pkg;

  localparam int CNT_W = 24;
  localparam int CLK_NS = 25;

  // Times in their own unit, nanoseconds
  localparam int MODESEL_NS = 3200;
  localparam int REARM_NS = 10000;
  localparam int RESET_NS = 4000000;
  localparam int BUS_WAKE_NS = 100000;
  localparam int LOCAL_WAKE_NS = 50000;
  localparam int RAMP_NS = 100000;
  localparam int WDOG_NS = 155000000;

  // Cycle counts; least times round up, the watchdog limit rounds down
  localparam logic [CNT_W-1:0] MODESEL_CYC = CNT_W'((MODESEL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] REARM_CYC = CNT_W'((REARM_NS + CLK_NS - 1) / CLK_NS + 1);
  localparam logic [CNT_W-1:0] BUS_REARM_CYC = CNT_W'(1);
  localparam logic [CNT_W-1:0] RESET_CYC = CNT_W'((RESET_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] BUS_WAKE_CYC = CNT_W'((BUS_WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LOCAL_WAKE_CYC = CNT_W'((LOCAL_WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RAMP_CYC = CNT_W'((RAMP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WDOG_CYC = CNT_W'(WDOG_NS / CLK_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // Wake sources
  localparam int NWAKE = 2;
  localparam int WK_BUS = 0;
  localparam int WK_LOCAL = 1;

  // Gray along unpowered, fail-safe, normal, silent, sleep
  typedef enum logic [2:0] {
    LSM_UNPOWERED = 3'h0,
    LSM_FAILSAFE  = 3'h1,
    LSM_NORMAL    = 3'h3,
    LSM_SILENT    = 3'h2,
    LSM_SLEEP     = 3'h6
  } lsm_mode_e;

  localparam lsm_mode_e MODE_RST = LSM_UNPOWERED;

endpackage

// file: inc/lsm_wake_if.sv
// Wake filter carrier between controller and filters
`timescale 1ns/1ps
interface lsm_wake_if;
  logic act;
  logic run;
  logic wake;
  modport filt (input act, input run, output wake);
  modport ctl (output act, output run, input wake);
endinterface

// file: testbench/lsm_host_model.sv
// Host controller model for enable, transmit and watchdog trigger pins
`timescale 1ns/1ps
module lsm_host_model (
  input  wire logic clk,
  input  wire logic want_en,
  input  wire logic want_tx,
  input  wire logic wd_run,
  output      logic en,
  output      logic tx,
  output      logic watchdog_trigger_n
);
  logic [6:0] cnt;
  initial begin
    en = 1'b0;
    tx = 1'b1;
    watchdog_trigger_n = 1'b1;
    cnt = 7'h00;
  end
  always @(posedge clk) begin
    en <= want_en;
    // Same edge as enable, so a sleep request drops both together
    // Held unchanged through the whole mode-select window
    tx <= want_tx;
    cnt <= cnt + 7'h01;
    // Falls every 128 cycles, well inside the timeout; stopped to provoke it
    watchdog_trigger_n <= wd_run ? ~cnt[6] : 1'b1;
  end
endmodule

// file: testbench/lsm_mode_ctrl_monitor.sv
// Port checks for the mode controller
`timescale 1ns/1ps
module lsm_mode_ctrl_monitor
  import lsm_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RESETN,
  input wire logic               EN,
  input wire logic               BATTERY_SUPPLY_LOW,
  input wire logic               VCC_UNDERVOLTAGE,
  input wire logic               BUS_BELOW_PREWAKE,
  input wire logic               RESET_OUT_N_I,
  input wire logic               RESET_OUT_N_OE,
  input wire logic               TX_DATA_PIN_O,
  input wire logic               TX_DATA_PIN_OE,
  input wire logic               RX_DATA_PIN,
  input wire logic               TX_PATH_EN,
  input wire logic               RX_PATH_EN,
  input wire logic               REGULATOR_EN,
  input wire logic               UV_DETECT_EN,
  input wire logic               WATCHDOG_EN,
  input wire logic               EXT_REGULATOR_SWITCH,
  input wire logic               TERMINATION_EN,
  input wire logic               BUS_RECEIVER_EN,
  input wire lsm_pkg::lsm_mode_e MODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire low_pwr = (MODE == LSM_SILENT) || (MODE == LSM_SLEEP);
  a_normal_outputs: assert property (
    MODE == LSM_NORMAL |-> TX_PATH_EN && RX_PATH_EN && REGULATOR_EN && UV_DETECT_EN
      && WATCHDOG_EN && EXT_REGULATOR_SWITCH) else $error("normal mode outputs wrong");
  // Sleep excluded: there the device itself holds the reset pin low
  a_pin_forces_fs: assert property (
    !RESET_OUT_N_I && (MODE == LSM_NORMAL || MODE == LSM_SILENT) |=> MODE == LSM_FAILSAFE)
    else $error("reset pin low did not force fail-safe");
  a_silent_outputs: assert property (
    MODE == LSM_SILENT |-> !TX_PATH_EN && REGULATOR_EN && !WATCHDOG_EN
      && !EXT_REGULATOR_SWITCH && RX_DATA_PIN) else $error("silent mode outputs wrong");
  a_sleep_outputs: assert property (
    MODE == LSM_SLEEP |-> !REGULATOR_EN && RESET_OUT_N_OE && !RX_DATA_PIN && !TX_PATH_EN
      && !WATCHDOG_EN && !EXT_REGULATOR_SWITCH) else $error("sleep mode outputs wrong");
  a_silent_uv: assert property (
    MODE == LSM_SILENT && VCC_UNDERVOLTAGE |=> MODE == LSM_FAILSAFE && RESET_OUT_N_OE)
    else $error("undervoltage in silent not handled");
  a_battery_low: assert property (
    low_pwr && BATTERY_SUPPLY_LOW |=> MODE == LSM_FAILSAFE)
    else $error("battery low in low power not handled");
  a_prewake_recv: assert property (
    (low_pwr && BUS_BELOW_PREWAKE) [*3] |-> BUS_RECEIVER_EN && TERMINATION_EN)
    else $error("prewake did not enable receiver");
  a_tx_drive_fs: assert property (
    TX_DATA_PIN_OE == (MODE == LSM_FAILSAFE)) else $error("transmit pin drive wrong");
  a_enable_normal: assert property (
    MODE == LSM_FAILSAFE && EN && !RESET_OUT_N_OE && RESET_OUT_N_I && !VCC_UNDERVOLTAGE
      |-> ##[1:2] MODE == LSM_NORMAL) else $error("enable did not reach normal");
  a_reset_holds: assert property (
    RESET_OUT_N_OE |-> MODE inside {LSM_FAILSAFE, LSM_SLEEP, LSM_UNPOWERED})
    else $error("mode left fail-safe during reset pulse");
  c_silent: cover property (MODE == LSM_SILENT);
  c_sleep: cover property (MODE == LSM_SLEEP);
  c_local_src: cover property (TX_DATA_PIN_OE && !TX_DATA_PIN_O);
endmodule

bind lsm_mode_ctrl lsm_mode_ctrl_monitor u_mon (
  .CLK(CLK), .RESETN(RESETN), .EN(EN), .BATTERY_SUPPLY_LOW(BATTERY_SUPPLY_LOW),
  .VCC_UNDERVOLTAGE(VCC_UNDERVOLTAGE), .BUS_BELOW_PREWAKE(BUS_BELOW_PREWAKE),
  .RESET_OUT_N_I(RESET_OUT_N_I), .RESET_OUT_N_OE(RESET_OUT_N_OE),
  .TX_DATA_PIN_O(TX_DATA_PIN_O), .TX_DATA_PIN_OE(TX_DATA_PIN_OE), .RX_DATA_PIN(RX_DATA_PIN),
  .TX_PATH_EN(TX_PATH_EN), .RX_PATH_EN(RX_PATH_EN), .REGULATOR_EN(REGULATOR_EN),
  .UV_DETECT_EN(UV_DETECT_EN), .WATCHDOG_EN(WATCHDOG_EN),
  .EXT_REGULATOR_SWITCH(EXT_REGULATOR_SWITCH), .TERMINATION_EN(TERMINATION_EN),
  .BUS_RECEIVER_EN(BUS_RECEIVER_EN), .MODE(MODE)
);

// file: testbench/lsm_mode_ctrl_tb_top.sv
// Self-checking bench for the mode controller
`timescale 1ns/1ps
module lsm_mode_ctrl_tb_top;
  import lsm_pkg::*;
  localparam int T_RST  = 50;
  localparam int T_RAMP = 10;
  localparam int T_WD   = 500;
  localparam int T_FILT = 20;
  logic      CLK, RESETN, want_en, want_tx, wd_run, ext_low;
  logic      bus_rx, prewake, local_sw, batt_low, vcc_uv;
  logic      en, tx, watchdog_trigger_n, tx_o, tx_oe, rx, rst_oe;
  logic      tx_en, rx_en, reg_en, uv_en, wd_en, ext_sw, term_en, brx_en;
  lsm_mode_e mode;
  int        error_cnt, num_checks, n;
  // Pins are resolved here: device drive wins on transmit, reset is open drain
  wire tx_pin  = tx_oe ? tx_o : tx;
  wire rst_pin = (rst_oe || ext_low) ? 1'b0 : 1'b1;

  lsm_host_model host (.clk(CLK), .want_en(want_en), .want_tx(want_tx), .wd_run(wd_run),
    .en(en), .tx(tx), .watchdog_trigger_n(watchdog_trigger_n));
  lsm_mode_ctrl #(.RESET_CYC(CNT_W'(T_RST)), .RAMP_CYC(CNT_W'(T_RAMP)),
    .WDOG_CYC(CNT_W'(T_WD)), .BUS_WAKE_CYC(CNT_W'(T_FILT)), .LOCAL_WAKE_CYC(CNT_W'(T_FILT)))
  dut (.CLK(CLK), .RESETN(RESETN), .EN(en), .TX_DATA_PIN_I(tx_pin), .TX_DATA_PIN_O(tx_o),
    .TX_DATA_PIN_OE(tx_oe), .RX_DATA_PIN(rx), .BUS_RX(bus_rx), .BUS_BELOW_PREWAKE(prewake),
    .LOCAL_SWITCH_INPUT(local_sw), .BATTERY_SUPPLY_LOW(batt_low), .VCC_UNDERVOLTAGE(vcc_uv),
    .WATCHDOG_TRIGGER_N(watchdog_trigger_n), .RESET_OUT_N_I(rst_pin), .RESET_OUT_N_O(),
    .RESET_OUT_N_OE(rst_oe), .TX_PATH_EN(tx_en), .RX_PATH_EN(rx_en), .REGULATOR_EN(reg_en),
    .UV_DETECT_EN(uv_en), .WATCHDOG_EN(wd_en), .EXT_REGULATOR_SWITCH(ext_sw),
    .TERMINATION_EN(term_en), .BUS_RECEIVER_EN(brx_en), .MODE(mode));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait, sampled at the falling edge where outputs are settled
  task automatic wait_mode(input lsm_mode_e m, input int lim);
    n = 0;
    @(negedge CLK);
    while (mode !== m && n < lim) begin
      @(negedge CLK);
      n++;
    end
    check(8'(mode), 8'(m));
  endtask

  task automatic go_low(input logic txv, input lsm_mode_e m);
    @(posedge CLK);
    want_tx <= txv;
    want_en <= 1'b0;
    wait_mode(m, 300);
  endtask

  task automatic go_normal;
    @(posedge CLK);
    want_tx <= 1'b1;
    want_en <= 1'b1;
    wait_mode(LSM_NORMAL, 300);
  endtask

  task automatic bus_pulse(input int len);
    @(posedge CLK);
    prewake <= 1'b1;
    bus_rx <= 1'b0;
    repeat (len) @(posedge CLK);
    bus_rx <= 1'b1;
    prewake <= 1'b0;
  endtask

  task automatic t_powerup;
    repeat (4) @(negedge CLK);
    check({4'h0, mode === LSM_FAILSAFE, reg_en, rst_oe, tx_en}, 8'h0E);
    repeat (20) @(negedge CLK);
    check(8'(mode), 8'(LSM_FAILSAFE));
    wait_mode(LSM_NORMAL, 300);
    check(8'(n > T_RAMP + T_RST - 30), 8'h01);
    check({2'h0, tx_en, rx_en, reg_en, uv_en, wd_en, ext_sw}, 8'h3F);
  endtask

  task automatic t_silent_bus;
    go_low(1'b1, LSM_SILENT);
    check(8'(n > 127), 8'h01);
    check({2'h0, tx_en, reg_en, wd_en, ext_sw, term_en, rx}, 8'h11);
    bus_pulse(5);
    repeat (5) @(negedge CLK);
    check({5'h0, mode === LSM_SILENT, term_en, brx_en}, 8'h07);
    bus_pulse(T_FILT + 10);
    wait_mode(LSM_FAILSAFE, 10);
    check({4'h0, rx, tx_oe, tx_o, ext_sw}, 8'h07);
    go_normal;
    check(8'(n < 4), 8'h01);
    check({6'h0, rx, tx_oe}, 8'h02);
    // A dominant bus is below the prewake level, so both move together
    @(posedge CLK);
    bus_rx <= 1'b0;
    prewake <= 1'b1;
    go_low(1'b1, LSM_SILENT);
    repeat (5) @(negedge CLK);
    check(8'(mode), 8'(LSM_SILENT));
    @(posedge CLK);
    bus_rx <= 1'b1;
    prewake <= 1'b0;
    wait_mode(LSM_FAILSAFE, 8);
    go_normal;
  endtask

  task automatic t_sleep_local;
    go_low(1'b0, LSM_SLEEP);
    check({3'h0, reg_en, rx, rst_oe, wd_en, ext_sw}, 8'h04);
    @(posedge CLK);
    local_sw <= 1'b0;
    wait_mode(LSM_FAILSAFE, 60);
    check({5'h0, rx, tx_oe, tx_o}, 8'h02);
    @(posedge CLK);
    local_sw <= 1'b1;
    go_normal;
    go_low(1'b0, LSM_SLEEP);
    @(posedge CLK);
    want_tx <= 1'b1;
    want_en <= 1'b1;
    wait_mode(LSM_FAILSAFE, 4);
    wait_mode(LSM_NORMAL, 300);
    @(posedge CLK);
    local_sw <= 1'b0;
    go_low(1'b1, LSM_SILENT);
    @(posedge CLK);
    local_sw <= 1'b1;
    repeat (5) @(posedge CLK);
    local_sw <= 1'b0;
    repeat (T_FILT + 10) @(negedge CLK);
    check(8'(mode), 8'(LSM_SILENT));
    @(posedge CLK);
    local_sw <= 1'b1;
    repeat (410) @(posedge CLK);
    local_sw <= 1'b0;
    wait_mode(LSM_FAILSAFE, 60);
    check({6'h0, tx_oe, tx_o}, 8'h02);
    @(posedge CLK);
    local_sw <= 1'b1;
    go_normal;
  endtask

  task automatic t_faults;
    go_low(1'b1, LSM_SILENT);
    @(posedge CLK);
    batt_low <= 1'b1;
    wait_mode(LSM_FAILSAFE, 4);
    @(posedge CLK);
    batt_low <= 1'b0;
    go_normal;
    go_low(1'b1, LSM_SILENT);
    @(posedge CLK);
    vcc_uv <= 1'b1;
    wait_mode(LSM_FAILSAFE, 4);
    check({7'h0, rst_oe}, 8'h01);
    @(posedge CLK);
    vcc_uv <= 1'b0;
    go_normal;
    @(posedge CLK);
    ext_low <= 1'b1;
    @(posedge CLK);
    ext_low <= 1'b0;
    wait_mode(LSM_FAILSAFE, 4);
    wait_mode(LSM_NORMAL, 300);
    @(posedge CLK);
    wd_run <= 1'b0;
    wait_mode(LSM_FAILSAFE, 700);
    check({6'h0, n > T_WD - 140, rst_oe}, 8'h03);
    @(posedge CLK);
    wd_run <= 1'b1;
    wait_mode(LSM_NORMAL, 300);
  endtask

  initial begin
    RESETN = 1'b0;
    want_en = 1'b0;
    want_tx = 1'b1;
    wd_run = 1'b1;
    ext_low = 1'b0;
    bus_rx = 1'b1;
    prewake = 1'b0;
    local_sw = 1'b1;
    batt_low = 1'b0;
    vcc_uv = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    // Early enable must wait out the power-up reset pulse
    want_en <= 1'b1;
    t_powerup;
    t_silent_bus;
    t_sleep_local;
    t_faults;
    stop_test;
  end

  // Whole run is a few thousand cycles; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge CLK);
    error_cnt++;
    stop_test;
  end
endmodule
